// ===== rtl/tsmc_mode_ctrl.sv
`timescale 1ns/100ps
`include "tsmc_regs.svh"

// What this block does
// R1 - mode decoded from run and duty bits
// R2 - continuous run accepts writes only to mode_control
// R3 - config stop answers all but soft reset writes, allows all writes
// R4 - interrupt released high at power-up
// R5 - mode_control powers up at 0x14
// R6 - slider_setup powers up at 0x81
// R7 - tick_period powers up at 0x05
// R8 - scan_interval powers up at 0x01
// R9 - sleep_setup powers up at 0x00
// R10 - continuous run paced by programmed tick
// R11 - other modes use fixed 8 ms tick
// R12 - tick code n gives n+5 ms, clamp
// R13 - duty run sleeps, bus may not answer
// R14 - host pulses attention before bus access
// R15 - off stop ignores bus, no scanning
// R16 - attention fall sets duty bit high
// R17 - only attention leaves duty and off modes
// R18 - interrupts spaced at least rate+1 ticks
// R19 - writing soft reset low resets controller
// R20 - duty bit active low enables duty cycling
// R21 - interrupt enable gates interrupt output
// R22 - run bit enables scanning
// R23 - soft reset restores all power-up values
// R24 - scan interval code clamps at 31
module tsmc_mode_ctrl
  import tsmc_pkg::*;
#(
  parameter logic [7:0] PART_INFO_VAL = 8'h5A, // arbitrary identity value
  parameter int         MS_CYCLES     = `TSMC_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire tsmc_req_s  bus_req,
  output tsmc_rsp_s       bus_rsp,
  input  wire logic       attention_pin_n,
  input  wire logic       touch_event,
  input  wire logic [7:0] event_queue_in,
  input  wire logic [7:0] fault_flags_in,
  input  wire logic [7:0] position_in,
  output tsmc_mode_e      mode,
  output logic            scan_enable,
  output logic            master_tick,
  output logic            interrupt_out_n
);

  logic [7:0] slider_setup_r;
  logic [7:0] touch_threshold_r;
  logic [7:0] tick_period_r;
  logic [7:0] scan_interval_r;
  logic [7:0] click_tone_r;
  logic [7:0] sleep_setup_r;
  logic [7:0] held_timeout_r;
  logic [7:0] mode_control_r;
  logic       attention_pin_n_prev_r;
  logic       attention_pin_n_fall;
  logic       soft_rst;
  logic       any_rst;
  logic       bus_live;
  logic       wr_ok;
  logic       wr_mode;
  logic [7:0] wdata_clamped;
  logic [7:0] tick_ms;
  logic [31:0] tick_cycles;
  logic [31:0] ms_cnt_r;
  logic [7:0]  tick_ms_cnt_r;
  logic        ms_pulse;
  logic [2:0]  irq_gap_r;
  logic        irq_pend_r;
  logic        irq_r;
  tsmc_rsp_s   rsp_r;

  // mode decode from run and duty bits
  always_comb begin
    unique case ({mode_control_r[`TSMC_BIT_RUN], mode_control_r[`TSMC_BIT_DUTY_N]}) // see R1
      2'b11:   mode = TSMC_CONT_RUN;
      2'b10:   mode = TSMC_DUTY_RUN;   // see R20
      2'b01:   mode = TSMC_CONFIG_STOP;
      2'b00:   mode = TSMC_OFF_STOP;
    endcase
  end

  assign scan_enable = mode_control_r[`TSMC_BIT_RUN]; // see R22

  // duty and off modes do not answer the bus
  assign bus_live = (mode == TSMC_CONT_RUN) || (mode == TSMC_CONFIG_STOP); // see R13 R15 R17
  assign wr_mode  = bus_req.wr && bus_live && (bus_req.addr == `TSMC_OFS_MODE_CONTROL);
  assign wr_ok    = bus_req.wr && (mode == TSMC_CONFIG_STOP); // see R2 R3

  // soft reset on writing soft reset bit low
  assign soft_rst = clk_en && wr_mode && !bus_req.wdata[`TSMC_BIT_SOFT_RST_N]; // see R19
  assign any_rst  = rst || soft_rst; // see R23

  assign attention_pin_n_fall = attention_pin_n_prev_r && !attention_pin_n;

  always_ff @(posedge clk) begin
    if (rst) begin
      attention_pin_n_prev_r <= 1'b1;
    end else if (clk_en) begin
      attention_pin_n_prev_r <= attention_pin_n;
    end
  end

  // clamp out-of-range codes
  always_comb begin
    wdata_clamped = bus_req.wdata;
    if (bus_req.addr == `TSMC_OFS_TICK_PERIOD && bus_req.wdata > `TSMC_TICK_MAX_CODE) begin
      wdata_clamped = `TSMC_TICK_MAX_CODE; // see R12
    end
    if (bus_req.addr == `TSMC_OFS_SCAN_INTERVAL && bus_req.wdata > `TSMC_SCAN_MAX_CODE) begin
      wdata_clamped = `TSMC_SCAN_MAX_CODE; // see R24
    end
  end

  // mode control register
  always_ff @(posedge clk) begin
    if (any_rst) begin
      mode_control_r <= `TSMC_RST_MODE_CONTROL; // see R5 R23
    end else if (clk_en) begin
      if (wr_mode) begin
        mode_control_r <= bus_req.wdata;
      end
      if (attention_pin_n_fall) begin
        mode_control_r[`TSMC_BIT_DUTY_N] <= 1'b1; // see R16
      end
    end
  end

  // configuration registers, writable only in config stop
  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_SLIDER_SETUP),
    .RESET_VAL (`TSMC_RST_SLIDER_SETUP) // see R6
  ) u_slider_setup (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (slider_setup_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_TOUCH_THRESHOLD),
    .RESET_VAL (`TSMC_RST_ZERO)
  ) u_touch_threshold (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (touch_threshold_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_TICK_PERIOD),
    .RESET_VAL (`TSMC_RST_TICK_PERIOD) // see R7
  ) u_tick_period (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (tick_period_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_SCAN_INTERVAL),
    .RESET_VAL (`TSMC_RST_SCAN_INTERVAL) // see R8
  ) u_scan_interval (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (scan_interval_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_CLICK_TONE),
    .RESET_VAL (`TSMC_RST_CLICK_TONE)
  ) u_click_tone (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (click_tone_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_SLEEP_SETUP),
    .RESET_VAL (`TSMC_RST_SLEEP_SETUP) // see R9
  ) u_sleep_setup (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (sleep_setup_r)
  );

  tsmc_cfg_reg #(
    .OFFSET    (`TSMC_OFS_HELD_TIMEOUT),
    .RESET_VAL (`TSMC_RST_ZERO)
  ) u_held_timeout (
    .clk    (clk),
    .rst    (any_rst),
    .clk_en (clk_en),
    .wr_en  (wr_ok),
    .addr   (bus_req.addr),
    .wdata  (wdata_clamped),
    .q      (held_timeout_r)
  );

  // read answer, one cycle after request
  always_ff @(posedge clk) begin
    if (any_rst) begin
      rsp_r <= '0;
    end else if (clk_en) begin
      rsp_r.ack <= (bus_req.rd || bus_req.wr) && bus_live; // see R3 R15
      if (bus_req.rd && bus_live) begin
        unique case (bus_req.addr)
          `TSMC_OFS_EVENT_QUEUE:     rsp_r.rdata <= event_queue_in;
          `TSMC_OFS_FAULT_FLAGS:     rsp_r.rdata <= fault_flags_in;
          `TSMC_OFS_POSITION_STATUS: rsp_r.rdata <= position_in;
          `TSMC_OFS_SLIDER_SETUP:    rsp_r.rdata <= slider_setup_r;
          `TSMC_OFS_TOUCH_THRESHOLD: rsp_r.rdata <= touch_threshold_r;
          `TSMC_OFS_TICK_PERIOD:     rsp_r.rdata <= tick_period_r;
          `TSMC_OFS_SCAN_INTERVAL:   rsp_r.rdata <= scan_interval_r;
          `TSMC_OFS_CLICK_TONE:      rsp_r.rdata <= click_tone_r;
          `TSMC_OFS_SLEEP_SETUP:     rsp_r.rdata <= sleep_setup_r;
          `TSMC_OFS_HELD_TIMEOUT:    rsp_r.rdata <= held_timeout_r;
          `TSMC_OFS_MODE_CONTROL:    rsp_r.rdata <= mode_control_r;
          `TSMC_OFS_PART_INFO:       rsp_r.rdata <= PART_INFO_VAL;
          default:                   rsp_r.rdata <= 8'h00;
        endcase
      end
    end
  end

  assign bus_rsp = rsp_r;

  // master tick length in ms
  always_comb begin
    if (mode == TSMC_CONT_RUN) begin
      tick_ms = tick_period_r + 8'(`TSMC_TICK_BASE_MS); // see R10 R12
    end else begin
      tick_ms = 8'(`TSMC_FIXED_TICK_MS); // see R11
    end
  end

  assign tick_cycles = 32'(MS_CYCLES);
  assign ms_pulse    = (ms_cnt_r == tick_cycles - 32'h1);

  // millisecond prescaler
  always_ff @(posedge clk) begin
    if (any_rst) begin
      ms_cnt_r <= 32'h0;
    end else if (clk_en) begin
      ms_cnt_r <= ms_pulse ? 32'h0 : ms_cnt_r + 32'h1;
    end
  end

  // tick counter in ms
  always_ff @(posedge clk) begin
    if (any_rst) begin
      tick_ms_cnt_r <= 8'h00;
      master_tick   <= 1'b0;
    end else if (clk_en) begin
      master_tick <= 1'b0;
      if (ms_pulse) begin
        if (tick_ms_cnt_r + 8'h1 >= tick_ms) begin
          tick_ms_cnt_r <= 8'h00;
          master_tick   <= 1'b1;
        end else begin
          tick_ms_cnt_r <= tick_ms_cnt_r + 8'h1;
        end
      end
    end
  end

  // interrupt spacing and gating
  always_ff @(posedge clk) begin
    if (any_rst) begin
      irq_gap_r  <= 3'h0;
      irq_pend_r <= 1'b0;
      irq_r      <= 1'b0; // see R4
    end else if (clk_en) begin
      if (!mode_control_r[`TSMC_BIT_IRQ_EN]) begin
        irq_pend_r <= 1'b0; // see R21
        irq_r      <= 1'b0;
      end else begin
        irq_r <= 1'b0;
        if (touch_event) begin
          irq_pend_r <= 1'b1;
        end
        if (master_tick && irq_gap_r != 3'h0) begin
          irq_gap_r <= irq_gap_r - 3'h1;
        end
        if ((irq_pend_r || touch_event) && irq_gap_r == 3'h0 && master_tick) begin
          irq_r      <= 1'b1;
          irq_pend_r <= 1'b0;
          irq_gap_r  <= mode_control_r[`TSMC_RATE_HI:`TSMC_RATE_LO]; // see R18
        end
      end
    end
  end

  assign interrupt_out_n = !irq_r;

endmodule

module tsmc_cfg_reg
  import tsmc_pkg::*;
#(
  parameter logic [3:0] OFFSET    = 4'h0,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  // one configuration byte, loads on a matching write
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else if (clk_en && wr_en && addr == OFFSET) begin
      q <= wdata;
    end
  end

endmodule

// ===== rtl/tsmc_pkg.sv
package tsmc_pkg;
  typedef enum logic [1:0] {
    TSMC_OFF_STOP,
    TSMC_CONFIG_STOP,
    TSMC_DUTY_RUN,
    TSMC_CONT_RUN
  } tsmc_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tsmc_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } tsmc_rsp_s;
endpackage

// ===== rtl/tsmc_regs.svh
`ifndef TSMC_REGS_SVH
`define TSMC_REGS_SVH

`define TSMC_OFS_EVENT_QUEUE     4'h0
`define TSMC_OFS_FAULT_FLAGS     4'h1
`define TSMC_OFS_POSITION_STATUS 4'h2
`define TSMC_OFS_SLIDER_SETUP    4'h3
`define TSMC_OFS_TOUCH_THRESHOLD 4'h4
`define TSMC_OFS_TICK_PERIOD     4'h5
`define TSMC_OFS_SCAN_INTERVAL   4'h6
`define TSMC_OFS_CLICK_TONE      4'h7
`define TSMC_OFS_SLEEP_SETUP     4'h8
`define TSMC_OFS_HELD_TIMEOUT    4'h9
`define TSMC_OFS_MODE_CONTROL    4'hA
`define TSMC_OFS_PART_INFO       4'hB

`define TSMC_RST_EVENT_QUEUE     8'h40
`define TSMC_RST_SLIDER_SETUP    8'h81
`define TSMC_RST_TICK_PERIOD     8'h05
`define TSMC_RST_SCAN_INTERVAL   8'h01
`define TSMC_RST_CLICK_TONE      8'h01
`define TSMC_RST_SLEEP_SETUP     8'h00
`define TSMC_RST_MODE_CONTROL    8'h14
`define TSMC_RST_ZERO            8'h00

`define TSMC_BIT_RUN             0
`define TSMC_BIT_IRQ_EN          1
`define TSMC_BIT_DUTY_N          2
`define TSMC_BIT_SOFT_RST_N      4
`define TSMC_RATE_HI             7
`define TSMC_RATE_LO             5

`define TSMC_TICK_MAX_CODE       8'h1A
`define TSMC_SCAN_MAX_CODE       8'h1F
`define TSMC_TICK_BASE_MS        5
`define TSMC_FIXED_TICK_MS       8
`define TSMC_CLK_HZ              10000000
`define TSMC_MS_CYCLES           (`TSMC_CLK_HZ / 1000)

`endif

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import tsmc_pkg::*;
;
  logic       clk = 1'b0;
  logic       clk_en = 1'b1;
  logic       rst = 1'b1;
  logic       touch_event = 1'b0;
  tsmc_req_s  bus_req;
  tsmc_rsp_s  bus_rsp;
  tsmc_mode_e mode;
  logic       attention_pin_n, scan_enable, master_tick, interrupt_out_n, ack;
  logic [7:0] q;
  int         error_cnt = 0, checked = 0, n;
  logic [7:0] exp_t [16] = '{8'h40, 8'h2C, 8'h13, 8'h81, 8'h00, 8'h05, 8'h01, 8'h01,
                             8'h00, 8'h00, 8'h14, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00};
  always #50 clk = ~clk;
  tsmc_mode_ctrl #(.PART_INFO_VAL(8'hA5), .MS_CYCLES(10)) u_tsmc_mode_ctrl (
    .clk, .rst, .clk_en, .bus_req, .bus_rsp, .attention_pin_n, .touch_event,
    .event_queue_in(8'h40), .fault_flags_in(8'h2C), .position_in(8'h13), .mode,
    .scan_enable, .master_tick, .interrupt_out_n);
  tsmc_host u_tsmc_host (.clk, .bus_rsp, .bus_req, .attention_pin_n);
  task automatic results();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_tsmc_host.xfer(1'b0, a, 8'h00, ack, q);
    chk({7'h00, ack}, 8'h01);
    chk(q, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_tsmc_host.xfer(1'b1, a, d, ack, q);
  endtask
  // cycles from one tick to the next
  task automatic gap(output int c);
    c = 0;
    while (master_tick !== 1'b1 && c < 400) @(negedge clk) c++;
    if (c >= 400) begin
      chk(8'h00, 8'h01);
      results();
    end
    c = 0;
    do @(negedge clk) c++; while (master_tick !== 1'b1 && c < 400);
  endtask
  // touch pulse, then cycles until interrupt low
  task automatic irq_wait(output int c, input int lim);
    c = 0;
    touch_event = 1'b1;
    do begin
      @(negedge clk);
      touch_event = 1'b0;
      c++;
    end while (interrupt_out_n !== 1'b0 && c < lim);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, interrupt_out_n}, 8'h01);
    for (int i = 0; i < 16; i++) rd(4'(i), exp_t[i]);
    wr(4'h5, 8'h1B);
    rd(4'h5, 8'h1A);
    wr(4'h6, 8'h20);
    rd(4'h6, 8'h1F);
    wr(4'h4, 8'h33);
    wr(4'h5, 8'h00);
    rd(4'h4, 8'h33);
    gap(n);
    chk(8'(n), 8'h50);
    wr(4'hA, 8'h37);
    chk({6'h00, mode}, {6'h00, TSMC_CONT_RUN});
    chk({7'h00, scan_enable}, 8'h01);
    wr(4'h4, 8'h77);
    rd(4'h4, 8'h33);
    rd(4'hA, 8'h37);
    gap(n);
    chk(8'(n), 8'h32);
    irq_wait(n, 400);
    chk({7'h00, n < 400}, 8'h01);
    irq_wait(n, 400);
    chk({7'h00, n >= 100 && n < 400}, 8'h01);
    wr(4'hA, 8'h11);
    chk({6'h00, mode}, {6'h00, TSMC_DUTY_RUN});
    u_tsmc_host.xfer(1'b1, 4'hA, 8'h17, ack, q);
    chk({7'h00, ack}, 8'h00);
    chk({6'h00, mode}, {6'h00, TSMC_DUTY_RUN});
    u_tsmc_host.wake();
    chk({6'h00, mode}, {6'h00, TSMC_CONT_RUN});
    irq_wait(n, 200);
    chk(8'(n), 8'hC8);
    wr(4'hA, 8'h10);
    u_tsmc_host.xfer(1'b0, 4'hA, 8'h00, ack, q);
    chk({7'h00, ack}, 8'h00);
    u_tsmc_host.wake();
    chk({6'h00, mode}, {6'h00, TSMC_CONFIG_STOP});
    wr(4'hA, 8'h07);
    rd(4'hA, 8'h14);
    rd(4'h5, 8'h05);
    rd(4'h4, 8'h00);
    gap(n);
    chk(8'(n), 8'h50);
    @(negedge clk) clk_en = 1'b0;
    u_tsmc_host.xfer(1'b1, 4'h4, 8'h5C, ack, q);
    chk({7'h00, ack}, 8'h00);
    @(negedge clk) clk_en = 1'b1;
    rd(4'h4, 8'h00);
    results();
  end
endmodule

// ===== verif/tsmc_host.sv
`timescale 1ns/100ps
module tsmc_host
  import tsmc_pkg::*;
(
  input  wire logic      clk,
  input  wire tsmc_rsp_s bus_rsp,
  output tsmc_req_s      bus_req,
  output logic           attention_pin_n
);
  initial begin
    bus_req = '0;
    attention_pin_n = 1'b1;
  end
  // one request, released after its taking edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic ack, output logic [7:0] q);
    @(negedge clk);
    bus_req = '{w, !w, a, d};
    @(negedge clk);
    bus_req = '{1'b0, 1'b0, ~a, ~d};
    ack = bus_rsp.ack;
    q = bus_rsp.rdata;
  endtask
  // wake pulse, only way out of sleep modes
  task automatic wake();
    @(negedge clk);
    attention_pin_n = 1'b0;
    repeat (3) @(negedge clk);
    attention_pin_n = 1'b1;
  endtask
endmodule

// ===== verif/tsmc_mode_ctrl_assertions.sv
`timescale 1ns/100ps
module tsmc_mode_ctrl_sva
  import tsmc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire tsmc_req_s  bus_req,
  input wire tsmc_rsp_s  bus_rsp,
  input wire logic       attention_pin_n,
  input wire tsmc_mode_e mode,
  input wire logic       scan_enable,
  input wire logic       master_tick,
  input wire logic       interrupt_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic req;
  logic live;
  logic srst;
  assign req  = clk_en && (bus_req.rd || bus_req.wr);
  assign live = mode inside {TSMC_CONT_RUN, TSMC_CONFIG_STOP};
  assign srst = bus_req.wr && bus_req.addr == 4'hA && !bus_req.wdata[4];
  a_reset_vals: assert property ($fell(rst)
    |-> mode == TSMC_CONFIG_STOP && interrupt_out_n)
    else $error("bad state after reset");
  a_scan_bit: assert property (
    scan_enable == (mode inside {TSMC_CONT_RUN, TSMC_DUTY_RUN}))
    else $error("scan enable wrong");
  a_ack_live: assert property (req && live && !srst |=> bus_rsp.ack)
    else $error("live bus not acked");
  a_ack_dead: assert property (req && !live |=> !bus_rsp.ack)
    else $error("ack while asleep");
  a_ack_cause: assert property (!req |=> !bus_rsp.ack)
    else $error("ack without request");
  a_attention_pin_n_wake: assert property ($fell(attention_pin_n) && mode == TSMC_DUTY_RUN
    |-> ##[1:3] mode == TSMC_CONT_RUN)
    else $error("attention did not wake");
  a_attention_pin_n_off: assert property (clk_en && $fell(attention_pin_n) && mode == TSMC_OFF_STOP
    |=> mode == TSMC_CONFIG_STOP)
    else $error("attention did not restore bus");
  a_soft_rst: assert property (req && live && srst |=> mode == TSMC_CONFIG_STOP)
    else $error("soft reset did not restore mode");
  a_tick_gap: assert property (master_tick |=> !master_tick [*8])
    else $error("ticks too close");
  a_irq_pulse: assert property (!interrupt_out_n |=> interrupt_out_n)
    else $error("interrupt too long");
endmodule
bind tsmc_mode_ctrl tsmc_mode_ctrl_sva u_tsmc_mode_ctrl_sva (.clk, .rst, .clk_en, .bus_req,
  .bus_rsp, .attention_pin_n, .mode, .scan_enable, .master_tick, .interrupt_out_n);
